// ==== common/jis_cfg.svh ====
// Purpose: Constants of the in-system programming test port block
// Assumes: 250 MHz core clock, 8-bit register bus
// Notes:   Opcodes and offsets are fixed values of this block
`ifndef JIS_CFG_SVH
`define JIS_CFG_SVH
// Register offsets
`define JIS_REG_CTRL     8'h00
`define JIS_REG_STATUS   8'h04
`define JIS_REG_IRQ_STAT 8'h08
`define JIS_REG_IRQ_CLR  8'h0C
`define JIS_REG_IRQ_EN   8'h10
`define JIS_REG_PROTECT  8'h14
`define JIS_CTRL_EN_BIT  0
// Instruction opcodes shifted in over the test port
`define JIS_OP_ISC_EN    8'h0C
`define JIS_OP_ISC_DIS   8'h0F
`define JIS_OP_STAT_ON   8'h10
`define JIS_OP_OD_ON     8'h11
`define JIS_OP_CLR_ERR   8'h12
`define JIS_OP_PROG      8'h20
`define JIS_OP_SECT_ERA  8'h21
`define JIS_OP_READ      8'h22
`define JIS_OP_CHIP_ERA  8'h23
`define JIS_OP_SET_SEC   8'h24
`define JIS_OP_SET_PROT  8'h25
`define JIS_OP_STATUS    8'h26
`define JIS_OP_BYPASS    8'hFF
`define JIS_IR_CAPTURE   8'h01
`define JIS_BLANK        8'hFF
// Flash operation time per operation and its cycle count
`define JIS_OP_TIME_NS   400
`define JIS_CLK_MHZ      250
`define JIS_OP_CYCLES    ((`JIS_OP_TIME_NS * `JIS_CLK_MHZ + 999) / 1000)
`endif

// ==== common/jis_pkg.sv ====
// Purpose: Types of the in-system programming test port block
// Assumes: Field widths written out here, no constants header included
// Notes:   All module state travels as packed structs
package jis_pkg;
	typedef enum logic [3:0] {
		T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SHIFT_DR, T_EX1_DR,
		T_PAUSE_DR, T_EX2_DR, T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SHIFT_IR,
		T_EX1_IR, T_PAUSE_IR, T_EX2_IR, T_UPD_IR
	} jis_tap_type;
	typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_SECT, OP_CHIP} jis_op_type;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic dedicated;
		logic sys_rst_n;
	} jis_pins_type;
	typedef struct packed {
		jis_pins_type s1;
		jis_pins_type s2;
	} jis_sync_type;
	typedef struct packed {
		logic       we;
		logic [3:0] addr;
		logic [7:0] data;
	} jis_mem_wr_type;
	typedef struct packed {
		logic [15:0][7:0] arr;
		logic [7:0]       rdata;
	} jis_mem_type;
	typedef struct packed {
		logic out;
		logic oe_n;
	} jis_pad_type;
	typedef struct packed {
		logic           tck_q;
		logic           rst_q;
		jis_tap_type    tap;
		logic [7:0]     ir;
		logic [15:0]    dr;
		logic           isc_on;
		logic           stat_en;
		logic           od_mode;
		logic           err;
		logic           secure;
		logic           dis_seen;
		logic           sw_en;
		logic [7:0]     protect;
		jis_op_type     op;
		logic [7:0]     timer;
		logic [3:0]     walk;
		logic [3:0]     last;
		logic [3:0]     addr;
		logic [7:0]     pdata;
		logic [2:0]     irq_stat;
		logic [2:0]     irq_en;
		logic [7:0]     rdata;
		logic           irq;
		jis_pad_type    stat_pad;
		jis_pad_type    err_pad;
		jis_pad_type    tdo_pad;
		jis_mem_wr_type mem_wr;
	} jis_state_type;
endpackage

// ==== verilog/jis_sync.sv ====
// Purpose: Two-stage synchroniser for all test port pins
// Assumes: Pins are asynchronous to core_clk
// Notes:   Only the second stage leaves this module
module jis_sync
	import jis_pkg::*;
(
	input  wire logic   core_clk,
	input  wire logic   rst_n,
	input  jis_pins_type d,
	output jis_pins_type q
);
	jis_sync_type st;
	jis_sync_type next_st;

	// First stage feeds only the second stage
	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) st <= '0;
		else st <= next_st;
	end

	assign q = st.s2;
endmodule

// ==== verilog/jis_flash_mem.sv ====
// Purpose: Small flash array model, sixteen bytes in eight sectors
// Assumes: One write port, one registered read port
// Notes:   Resets to the blank value; read data lag the address by one
`include "jis_cfg.svh"
module jis_flash_mem
	import jis_pkg::*;
(
	input  wire logic     core_clk,
	input  wire logic     rst_n,
	input  jis_mem_wr_type wr,
	input  wire logic [3:0] raddr,
	output logic [7:0]    rdata
);
	jis_mem_type st;
	jis_mem_type next_st;

	// Write one byte, register the read byte
	always_comb begin
		next_st = st;
		if (wr.we) next_st.arr[wr.addr] = wr.data;
		next_st.rdata = st.arr[raddr];
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) st <= '{arr: {16{`JIS_BLANK}}, rdata: `JIS_BLANK};
		else st <= next_st;
	end

	assign rdata = st.rdata;
endmodule

// ==== verilog/jis_isp_port.sv ====
// Purpose: In-system programming side of the test access port
// Assumes: TCK at least eight core clocks per half period
// Notes:   Test pins are oversampled, no second clock domain
// What this block does
// - Take programming commands, no boundary scan
// - Status pins idle until enable command
// - Status shown continuously on the pins
// - Error pin low on erase/program failure
// - Error holds until clear command, or device reset after disable command
// - Ready pin high in read-array mode
// - Ready pin low during flash program/erase
// - Ready pin low while boot block written
// - Command switches status pins to open-drain
// - Secured part refuses every memory read
// - Secured part accepts only chip erase
// - Secured part blocks program, erase, verify
// - Chip erase clears security, leaves blank
// - Protected sector is never sector-erased; chip erase still blanks it
// - Enable bit 0 turns test pins on
// - Reset aborts only software-enabled port
//
// Chosen here: the register addresses and the plain strobed port.
`include "jis_cfg.svh"
module jis_isp_port
	import jis_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       tck_pin,
	input  wire logic       tms_pin,
	input  wire logic       tdi_pin,
	input  wire logic       jtag_dedicated_pin,
	input  wire logic       sys_reset_n_pin,
	output logic            tdo_out,
	output logic            tdo_oe_n,
	output logic            prog_status_out,
	output logic            prog_status_oe_n,
	output logic            prog_error_out,
	output logic            prog_error_oe_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	output logic            irq
);
	localparam jis_pad_type PAD_OFF = '{out: 1'b0, oe_n: 1'b1};
	localparam jis_state_type ST_INIT = '{
		tap: T_RESET, ir: `JIS_OP_BYPASS, op: OP_IDLE,
		stat_pad: PAD_OFF, err_pad: PAD_OFF, tdo_pad: PAD_OFF,
		default: '0};

	jis_state_type st;
	jis_state_type next_st;
	jis_pins_type  raw;
	jis_pins_type  sy;
	logic [7:0]    mem_rdata;
	logic          tck_rise;
	logic          tck_fall;
	logic          port_on;
	logic          abort;
	logic          ir_go;
	logic          dr_go;
	logic          flash_cmd;
	logic          blocked;
	logic          clr_cmd;
	logic          rst_clr;
	logic [2:0]    irq_clr;
	logic          ev_done;
	logic          ev_err;

	assign raw = '{tck: tck_pin, tms: tms_pin, tdi: tdi_pin,
		dedicated: jtag_dedicated_pin, sys_rst_n: sys_reset_n_pin};

	jis_sync u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.d        (raw),
		.q        (sy)
	);

	jis_flash_mem u_mem (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr       (st.mem_wr),
		.raddr    (st.addr),
		.rdata    (mem_rdata)
	);

	// Standard test state walk on each sampled TCK rise
	function automatic jis_tap_type tap_next(jis_tap_type s, logic m);
		case (s)
		T_RESET:    tap_next = m ? T_RESET : T_IDLE;
		T_IDLE:     tap_next = m ? T_SEL_DR : T_IDLE;
		T_SEL_DR:   tap_next = m ? T_SEL_IR : T_CAP_DR;
		T_CAP_DR:   tap_next = m ? T_EX1_DR : T_SHIFT_DR;
		T_SHIFT_DR: tap_next = m ? T_EX1_DR : T_SHIFT_DR;
		T_EX1_DR:   tap_next = m ? T_UPD_DR : T_PAUSE_DR;
		T_PAUSE_DR: tap_next = m ? T_EX2_DR : T_PAUSE_DR;
		T_EX2_DR:   tap_next = m ? T_UPD_DR : T_SHIFT_DR;
		T_UPD_DR:   tap_next = m ? T_SEL_DR : T_IDLE;
		T_SEL_IR:   tap_next = m ? T_RESET : T_CAP_IR;
		T_CAP_IR:   tap_next = m ? T_EX1_IR : T_SHIFT_IR;
		T_SHIFT_IR: tap_next = m ? T_EX1_IR : T_SHIFT_IR;
		T_EX1_IR:   tap_next = m ? T_UPD_IR : T_PAUSE_IR;
		T_PAUSE_IR: tap_next = m ? T_EX2_IR : T_PAUSE_IR;
		T_EX2_IR:   tap_next = m ? T_UPD_IR : T_SHIFT_IR;
		T_UPD_IR:   tap_next = m ? T_SEL_DR : T_IDLE;
		default:    tap_next = T_RESET;
		endcase
	endfunction

	// Pad drive: off, open-drain (pull low only) or push-pull
	function automatic jis_pad_type pad_of(logic en, logic od, logic v);
		if (!en) pad_of = PAD_OFF;
		else if (od) pad_of = '{out: 1'b0, oe_n: v};
		else pad_of = '{out: v, oe_n: 1'b0};
	endfunction

	// Edges of the oversampled test clock
	assign tck_rise = sy.tck & ~st.tck_q;
	assign tck_fall = ~sy.tck & st.tck_q;
	// Pins live when strapped or enabled by software
	assign port_on = sy.dedicated | st.sw_en;
	// Device reset aborts only a software-enabled port
	assign abort = ~sy.dedicated & ~sy.sys_rst_n;
	assign ir_go = port_on & ~abort & tck_rise & (st.tap == T_UPD_IR);
	assign dr_go = port_on & ~abort & tck_rise & (st.tap == T_UPD_DR);
	// Memory commands that a secured part must refuse
	assign flash_cmd = (st.ir == `JIS_OP_PROG) ||
		(st.ir == `JIS_OP_SECT_ERA) || (st.ir == `JIS_OP_READ) ||
		(st.ir == `JIS_OP_SET_PROT);
	assign blocked = dr_go & st.secure & flash_cmd;
	assign clr_cmd = ir_go & (st.ir == `JIS_OP_CLR_ERR);
	// Reset pulse only clears the error after a disable command
	assign rst_clr = st.dis_seen & st.rst_q & ~sy.sys_rst_n;
	assign irq_clr = (reg_wr && reg_addr == `JIS_REG_IRQ_CLR) ?
		reg_wdata[2:0] : 3'h0;

	// Whole next state of the block
	always_comb begin
		next_st = st;
		ev_done = 1'b0;
		ev_err = 1'b0;
		next_st.tck_q = sy.tck;
		next_st.rst_q = sy.sys_rst_n;
		next_st.mem_wr.we = 1'b0;

		// Test state machine; only ISP registers, no scan chain
		if (abort || !port_on) begin
			next_st.tap = T_RESET;
			next_st.ir = `JIS_OP_BYPASS;
		end else if (tck_rise) begin
			next_st.tap = tap_next(st.tap, sy.tms);
			case (st.tap)
			T_RESET: begin
				next_st.ir = `JIS_OP_BYPASS;
			end
			T_CAP_IR: begin
				next_st.ir = `JIS_IR_CAPTURE;
			end
			T_SHIFT_IR: begin
				next_st.ir = {sy.tdi, st.ir[7:1]};
			end
			T_CAP_DR: begin
				if (st.ir == `JIS_OP_READ)
					next_st.dr = st.secure ? 16'h0000 :
						{4'h0, st.addr, mem_rdata};
				else if (st.ir == `JIS_OP_STATUS)
					next_st.dr = {11'h000, st.op != OP_IDLE, st.err,
						st.secure, st.stat_en, st.isc_on};
				else
					next_st.dr = 16'h0000;
			end
			T_SHIFT_DR: begin
				next_st.dr = {sy.tdi, st.dr[15:1]};
			end
			default: begin
			end
			endcase
		end

		// TDO changes on the falling test clock, driven only in shifts
		if (abort || !port_on)
			next_st.tdo_pad = PAD_OFF;
		else if (tck_fall) begin
			if (st.tap == T_SHIFT_DR)
				next_st.tdo_pad = '{out: st.dr[0], oe_n: 1'b0};
			else if (st.tap == T_SHIFT_IR)
				next_st.tdo_pad = '{out: st.ir[0], oe_n: 1'b0};
			else
				next_st.tdo_pad = PAD_OFF;
		end

		// Instruction-only commands run at update of the instruction
		if (ir_go) begin
			case (st.ir)
			`JIS_OP_ISC_EN: begin
				next_st.isc_on = 1'b1;
				next_st.dis_seen = 1'b0;
			end
			`JIS_OP_ISC_DIS: begin
				next_st.isc_on = 1'b0;
				next_st.dis_seen = 1'b1;
			end
			`JIS_OP_STAT_ON: begin
				next_st.stat_en = 1'b1;
			end
			`JIS_OP_OD_ON: begin
				next_st.od_mode = 1'b1;
			end
			`JIS_OP_SET_SEC: begin
				if (st.isc_on && st.op == OP_IDLE) next_st.secure = 1'b1;
			end
			`JIS_OP_CHIP_ERA: begin
				// Allowed even when secured
				if (st.isc_on && st.op == OP_IDLE) begin
					next_st.op = OP_CHIP;
					next_st.walk = 4'h0;
					next_st.last = 4'hF;
					next_st.timer = 8'(`JIS_OP_CYCLES);
				end
			end
			default: begin
			end
			endcase
		end

		// Data commands; a secured part drops them untouched
		if (dr_go && !st.secure && st.isc_on && st.op == OP_IDLE) begin
			case (st.ir)
			`JIS_OP_PROG: begin
				next_st.op = OP_PROG;
				next_st.addr = st.dr[11:8];
				next_st.pdata = st.dr[7:0];
				next_st.timer = 8'(`JIS_OP_CYCLES);
			end
			`JIS_OP_SECT_ERA: begin
				// Sector is addr[3:1], addr sits in dr[11:8]
				if (st.protect[st.dr[11:9]])
					ev_err = 1'b1;
				else begin
					next_st.op = OP_SECT;
					next_st.walk = {st.dr[11:9], 1'b0};
					next_st.last = {st.dr[11:9], 1'b1};
					next_st.timer = 8'(`JIS_OP_CYCLES);
				end
			end
			`JIS_OP_READ: begin
				next_st.addr = st.dr[11:8];
			end
			`JIS_OP_SET_PROT: begin
				next_st.protect = st.protect | st.dr[7:0];
			end
			default: begin
			end
			endcase
		end

		// Flash engine: wait the op time, then write the bytes
		if (st.op != OP_IDLE) begin
			if (st.timer != 8'h00)
				next_st.timer = st.timer - 8'h01;
			else if (st.op == OP_PROG) begin
				// Flash can only clear bits; a set bit is a failure
				next_st.mem_wr = '{we: 1'b1, addr: st.addr,
					data: mem_rdata & st.pdata};
				ev_err = (mem_rdata & st.pdata) != st.pdata;
				next_st.op = OP_IDLE;
				ev_done = 1'b1;
			end else begin
				next_st.mem_wr = '{we: 1'b1, addr: st.walk,
					data: `JIS_BLANK};
				next_st.walk = st.walk + 4'h1;
				if (st.walk == st.last) begin
					next_st.op = OP_IDLE;
					ev_done = 1'b1;
					if (st.op == OP_CHIP) next_st.secure = 1'b0;
				end
			end
		end
		if (abort) next_st.op = OP_IDLE;

		// Sticky error, new failure wins over a clear
		next_st.err = (st.err & ~(clr_cmd | rst_clr)) | ev_err;
		if (rst_clr) next_st.dis_seen = 1'b0;

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
			`JIS_REG_CTRL: next_st.sw_en = reg_wdata[`JIS_CTRL_EN_BIT];
			`JIS_REG_IRQ_EN: next_st.irq_en = reg_wdata[2:0];
			default: begin
			end
			endcase
		end
		next_st.irq_stat = (st.irq_stat & ~irq_clr) |
			{blocked, ev_err, ev_done};

		// Register reads, answered in the next cycle
		next_st.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
			`JIS_REG_CTRL: next_st.rdata = {7'h00, st.sw_en};
			`JIS_REG_STATUS: next_st.rdata = {2'h0, st.od_mode,
				st.stat_en, st.isc_on, st.secure, st.err,
				st.op != OP_IDLE};
			`JIS_REG_IRQ_STAT: next_st.rdata = {5'h00, st.irq_stat};
			`JIS_REG_IRQ_EN: next_st.rdata = {5'h00, st.irq_en};
			`JIS_REG_PROTECT: next_st.rdata = st.protect;
			default: next_st.rdata = 8'h00;
			endcase
		end
		next_st.irq = |(next_st.irq_stat & next_st.irq_en);

		// Pins track state every cycle once enabled, so no serial polling needed
		next_st.stat_pad = pad_of(next_st.stat_en, next_st.od_mode,
			next_st.op == OP_IDLE);
		next_st.err_pad = pad_of(next_st.stat_en, next_st.od_mode,
			~next_st.err);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) st <= ST_INIT;
		else st <= next_st;
	end

	// Outputs straight from the state register
	assign tdo_out = st.tdo_pad.out;
	assign tdo_oe_n = st.tdo_pad.oe_n;
	assign prog_status_out = st.stat_pad.out;
	assign prog_status_oe_n = st.stat_pad.oe_n;
	assign prog_error_out = st.err_pad.out;
	assign prog_error_oe_n = st.err_pad.oe_n;
	assign reg_rdata = st.rdata;
	assign irq = st.irq;

	// Checks on the behaviour above
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_pins_idle_off: assert property (!st.stat_en |->
		prog_status_oe_n && prog_error_oe_n)
		else $error("status pins driven before enable");
	a_busy_drives_low: assert property (
		$rose(st.op != OP_IDLE) && st.stat_en && !st.od_mode
		|-> !prog_status_out [*8])
		else $error("ready pin not low during flash op");
	a_ready_high: assert property (st.stat_en && !st.od_mode &&
		st.op == OP_IDLE |-> prog_status_out)
		else $error("ready pin low in read-array mode");
	a_err_sticky: assert property (st.err && !clr_cmd && !rst_clr
		|=> st.err && $stable(st.err))
		else $error("error flag lost without clear");
	a_err_pin_low: assert property (ev_err && st.stat_en
		|=> !prog_error_out && (st.od_mode ? !prog_error_oe_n : 1'b1))
		else $error("error pin not low after failure");
	a_od_no_high: assert property (st.od_mode && st.stat_en
		|-> !prog_status_out && !prog_error_out)
		else $error("open-drain pin driven high");
	a_secure_ops: assert property (blocked
		|=> $stable(st.protect) && $stable(st.secure)
		&& st.op == OP_IDLE)
		else $error("blocked command changed state");
	a_secure_read: assert property (
		tck_rise && st.tap == T_CAP_DR &&
		st.ir == `JIS_OP_READ && st.secure && port_on && !abort
		|=> st.dr == 16'h0000)
		else $error("secured part returned memory data");
	a_secure_chip: assert property (st.secure |->
		st.op == OP_IDLE || st.op == OP_CHIP)
		else $error("secured part ran a non-chip-erase op");
	// Last byte of a chip erase: part unsecured, blank byte written
	a_chip_unsecure: assert property (st.op == OP_CHIP &&
		st.timer == 8'h00 && st.walk == 4'hF && !abort
		|=> !st.secure && st.op == OP_IDLE && st.mem_wr.we &&
		st.mem_wr.data == `JIS_BLANK)
		else $error("chip erase left part secured");
	a_prot_kept: assert property (st.op == OP_SECT |->
		!st.protect[st.walk[3:1]])
		else $error("protected sector being erased");
	a_abort_tap: assert property (abort
		|=> st.tap == T_RESET && st.op == OP_IDLE)
		else $error("reset did not abort the port");
	a_port_off: assert property (!port_on |=> st.tap == T_RESET
		&& tdo_oe_n)
		else $error("disabled port still active");

	c_chip_erase: cover property (st.op == OP_CHIP ##1 st.op == OP_IDLE);
	c_prog_fail: cover property (ev_err && st.op == OP_PROG);
	c_blocked: cover property (blocked);
	c_od_mode: cover property (st.od_mode && st.stat_en);
endmodule

// ==== testbench/jis_tap_ctrl.sv ====
// Purpose: Behavioural test-port programming controller for the bench
// Assumes: TCK half period of 20 core clocks, 160 ns link period
// Notes:   TCK rests low between frames; TDI idles at inverse of last bit
module jis_tap_ctrl
	import jis_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic tdo_line,
	output logic      tck,
	output logic      tms,
	output logic      tdi
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 20;

	// Link at rest until the first frame
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One TCK period; TDO is taken just before the rise
	task automatic step(input logic m, input logic d, output logic q);
		@(posedge core_clk);
		tms <= m;
		tdi <= d;
		// One cycle already spent above, so a period is 2*HALF
		repeat (HALF - 1) @(posedge core_clk);
		q = tdo_line;
		tck <= 1'b1;
		repeat (HALF) @(posedge core_clk);
		tck <= 1'b0;
	endtask

	// Five ones reach reset from any state, then park in idle
	task automatic reset_tap();
		logic q;
		repeat (5) step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask

	// IR or DR scan from idle back to idle, LSB first
	task automatic scan(input logic ir, input logic [15:0] din,
		input int n, output logic [15:0] dout);
		logic q;
		dout = 16'h0000;
		step(1'b1, ~tdi, q);
		if (ir) step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~din[n - 1], q);
		step(1'b0, ~din[n - 1], q); // Command runs on this rise
	endtask
endmodule

// ==== testbench/tb_jis_isp_port.sv ====
// Purpose: Self-checking bench of the test port programming block
// Assumes: Status, error and TDO lines carry board pull-ups
// Notes:   Flash ops are short, so every wait is a bounded count
`include "jis_cfg.svh"
module tb_jis_isp_port
	import jis_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 60000; // About one and a half times the planned run
	logic        core_clk, rst_n, tck, tms, tdi, strap, sys_rst_n;
	logic        tdo_out, tdo_oe_n, st_out, st_oe_n, er_out, er_oe_n;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, irq;
	logic [15:0] cap;
	int          n_mismatch = 0;
	int          compares = 0;
	int          cycles = 0;
	// Released or open-drain lines sit at the pull-up level
	wire tdo_line = tdo_oe_n ? 1'b1 : tdo_out;
	wire st_pin   = st_oe_n ? 1'b1 : st_out;
	wire er_pin   = er_oe_n ? 1'b1 : er_out;

	jis_isp_port u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
		.jtag_dedicated_pin(strap), .sys_reset_n_pin(sys_rst_n),
		.tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
		.prog_status_out(st_out), .prog_status_oe_n(st_oe_n),
		.prog_error_out(er_out), .prog_error_oe_n(er_oe_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	jis_tap_ctrl u_ctrl (.core_clk(core_clk), .tdo_line(tdo_line),
		.tck(tck), .tms(tms), .tdi(tdi));

	// 250 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Cut a hang short
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Register bus: one-cycle strobes, read data in the next cycle only
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, 16'(reg_rdata), 16'(exp));
	endtask

	// Test-port commands through the partner controller
	task automatic cmd(input logic [7:0] op);
		u_ctrl.scan(1'b1, {8'h00, op}, 8, cap);
	endtask

	task automatic dr(input logic [15:0] d);
		u_ctrl.scan(1'b0, d, 16, cap);
	endtask

	task automatic prog(input logic [3:0] a, input logic [7:0] d);
		cmd(`JIS_OP_PROG);
		dr({4'h0, a, d});
	endtask

	task automatic readback(input logic [3:0] a, input logic [15:0] exp);
		cmd(`JIS_OP_READ);
		dr({4'h0, a, 8'h00});
		dr(16'h0000);
		chk("readback", cap, exp);
	endtask

	// Ready is polled on the pin, as a controller would
	task automatic wait_ready();
		int k;
		k = 0;
		while (st_pin !== 1'b1 && k < 400) begin
			@(posedge core_clk);
			k++;
		end
		chk("ready", 16'(st_pin), 16'h0001);
	endtask

	task automatic sys_pulse();
		@(posedge core_clk);
		sys_rst_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		sys_rst_n <= 1'b1;
		repeat (10) @(posedge core_clk);
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		strap = 1'b0;
		sys_rst_n = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk("pads idle", 16'({st_oe_n, er_oe_n, tdo_oe_n}), 16'h0007);
		rd(`JIS_REG_STATUS, 8'h00, "status");
		rd(8'h1C, 8'h00, "unmapped");
		cmd(`JIS_OP_ISC_EN);
		cmd(`JIS_OP_STAT_ON);
		chk("disabled", 16'(st_oe_n), 16'h0001);
		wr(`JIS_REG_CTRL, 8'h01);
		rd(`JIS_REG_CTRL, 8'h01, "ctrl");
		// The state walk sat in reset while off, so park it in idle
		u_ctrl.reset_tap();
		cmd(`JIS_OP_ISC_EN);
		chk("stat off", 16'(st_oe_n), 16'h0001);
		rd(`JIS_REG_STATUS, 8'h08, "isc on");
		cmd(`JIS_OP_STAT_ON);
		chk("pads on", 16'({st_oe_n, st_out, er_oe_n, er_out}), 16'h0005);
		wr(`JIS_REG_IRQ_EN, 8'h07);
		prog(4'h2, 8'h5A);
		chk("busy pin", 16'(st_pin), 16'h0000);
		rd(`JIS_REG_STATUS, 8'h19, "busy");
		wait_ready();
		rd(`JIS_REG_IRQ_STAT, 8'h01, "done");
		chk("irq", 16'(irq), 16'h0001);
		wr(`JIS_REG_IRQ_CLR, 8'h01);
		rd(`JIS_REG_IRQ_STAT, 8'h00, "cleared");
		chk("irq off", 16'(irq), 16'h0000);
		readback(4'h2, 16'h025A);
		prog(4'h2, 8'hFF);
		wait_ready();
		chk("err pin", 16'(er_pin), 16'h0000);
		prog(4'h3, 8'h00);
		wait_ready();
		chk("err held", 16'(er_pin), 16'h0000);
		cmd(`JIS_OP_CLR_ERR);
		chk("err clear", 16'(er_pin), 16'h0001);
		cmd(`JIS_OP_SET_PROT);
		dr(16'h0002);
		rd(`JIS_REG_PROTECT, 8'h02, "protect");
		cmd(`JIS_OP_SECT_ERA);
		dr(16'h0200);
		wait_ready();
		chk("prot err", 16'(er_pin), 16'h0000);
		readback(4'h2, 16'h025A);
		cmd(`JIS_OP_CLR_ERR);
		prog(4'h6, 8'h33);
		wait_ready();
		cmd(`JIS_OP_SECT_ERA);
		dr(16'h0600);
		wait_ready();
		readback(4'h6, 16'h06FF);
		cmd(`JIS_OP_OD_ON);
		chk("od pads", 16'({st_out, st_oe_n, er_out, er_oe_n}), 16'h0005);
		wr(`JIS_REG_IRQ_CLR, 8'h07);
		cmd(`JIS_OP_SET_SEC);
		rd(`JIS_REG_STATUS, 8'h3C, "secure");
		readback(4'h2, 16'h0000);
		prog(4'h6, 8'h00);
		chk("no busy", 16'(st_pin), 16'h0001);
		cmd(`JIS_OP_SECT_ERA);
		dr(16'h0600);
		cmd(`JIS_OP_SET_PROT);
		dr(16'h00F0);
		rd(`JIS_REG_PROTECT, 8'h02, "prot kept");
		rd(`JIS_REG_STATUS, 8'h3C, "no err");
		rd(`JIS_REG_IRQ_STAT, 8'h04, "blocked");
		wr(`JIS_REG_IRQ_EN, 8'h00);
		repeat (2) @(posedge core_clk);
		chk("masked", 16'(irq), 16'h0000);
		wr(`JIS_REG_IRQ_EN, 8'h07);
		repeat (2) @(posedge core_clk);
		chk("unmasked", 16'(irq), 16'h0001);
		wr(`JIS_REG_IRQ_CLR, 8'h07);
		cmd(`JIS_OP_CHIP_ERA);
		chk("erase busy", 16'(st_pin), 16'h0000);
		wait_ready();
		rd(`JIS_REG_STATUS, 8'h38, "unsecured");
		readback(4'h2, 16'h02FF);
		prog(4'h2, 8'h00);
		wait_ready();
		prog(4'h2, 8'h01);
		wait_ready();
		cmd(`JIS_OP_ISC_DIS);
		sys_pulse();
		chk("reset clear", 16'(er_pin), 16'h0001);
		u_ctrl.reset_tap();
		cmd(`JIS_OP_ISC_EN);
		prog(4'h4, 8'h11);
		sys_pulse();
		chk("aborted", 16'(st_pin), 16'h0001);
		strap <= 1'b1;
		u_ctrl.reset_tap();
		cmd(`JIS_OP_ISC_EN);
		prog(4'h6, 8'h22);
		sys_pulse();
		chk("not aborted", 16'(st_pin), 16'h0000);
		wait_ready();
		readback(4'h6, 16'h0622);
		stop_test();
	end
endmodule
